// ===== rtl/mmr_slave.sv
// slave end: small memory with byte lanes, rom mode and per-beat responses
// What this block does
// - side-effect-free reads ignore byte enables
// - missing byte enables mean all lanes enabled
// - master enables only adjacent byte lanes
// - debug access lets writes reach rom memory
// - read strobe requests read; read data present
// - slave returns read data for every read
// - never read and write response together
// - response codes okay, slave error, decode error
// - one response per read beat, always
// - read responses need read control, data valid
// - master ignores data of error beats
// - one write response after last burst beat
// - every write command gets write response
// - enable bit n governs byte n
`include "mmr_params.svh"
module mmr_slave #(
	parameter int DW = `MMR_DATA_W,
	parameter int AW = `MMR_ADDR_W,
	parameter int BW = `MMR_BURST_W,
	parameter int WORDS = `MMR_MEM_WORDS,
	parameter bit HAS_BE = 1'b1
) (
	// bus side
	mmr_if.slv bus,
	// configuration
	input wire logic cfg_rom,
	// status
	output logic stat_err_seen
);
	import mmr_pkg::*;
	// byte lanes and array index width follow from the parameters
	localparam int NB = DW / 8;
	localparam int IW = $clog2(WORDS);
	typedef enum {ST_IDLE, ST_RD, ST_WR, ST_WRSP} mmr_st_t;

	mmr_st_t state_ff;
	logic [AW-1:0] addr_ff;
	logic [BW-1:0] left_ff;
	logic wr_bad_ff;
	logic wr_dec_ff;
	logic [DW-1:0] rdata_ff;
	logic rvalid_ff;
	logic wvalid_ff;
	mmr_rsp_t rsp_ff;
	logic err_ff;
	logic [NB-1:0] lane_en;
	logic [BW-1:0] req_len;
	logic wr_take;
	logic in_range;
	logic wr_in_range;
	logic rd_beat;
	logic [IW-1:0] wr_idx;
	logic [IW-1:0] rd_idx;
	logic [DW-1:0] rd_word;

	// without a byte enable port every lane counts as enabled;
	// with HAS_BE cleared the master's lane choice is simply lost
	assign lane_en = HAS_BE ? bus.byteenable : {NB{1'b1}};
	assign req_len = (bus.burstcount == '0) ? BW'(1) : bus.burstcount;
	// accept writes only while no response is pending; this keeps the
	// shared response bus free of read/write overlap
	assign bus.waitrequest = (state_ff == ST_RD) || (state_ff == ST_WRSP) ||
		rvalid_ff || wvalid_ff;
	assign wr_take = bus.write && !bus.waitrequest &&
		(state_ff == ST_IDLE || state_ff == ST_WR);
	// addresses past the array are decode faults; the range tests run
	// on the full address so that the index cut below cannot alias
	assign in_range = 32'(addr_ff) < WORDS;
	assign wr_in_range = 32'(state_ff == ST_WR ? addr_ff : bus.address) <
		WORDS;
	assign wr_idx = IW'(state_ff == ST_WR ? addr_ff : bus.address);
	assign rd_idx = IW'(addr_ff);
	// a read beat every other cycle: the gap lets the response fall
	assign rd_beat = (state_ff == ST_RD) && !rvalid_ff;

	// control state: bursts counted beat by beat
	// the burst length is latched once; later burstcount changes are ignored
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			state_ff <= ST_IDLE;
			addr_ff <= '0;
			left_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (bus.read && !bus.waitrequest) begin
						state_ff <= ST_RD;
						addr_ff <= bus.address;
						left_ff <= req_len;
					end else if (wr_take) begin
						addr_ff <= bus.address + AW'(1);
						left_ff <= req_len - BW'(1);
						state_ff <= (req_len == BW'(1)) ? ST_WRSP : ST_WR;
					end
				end
				ST_RD: begin
					if (rd_beat) begin
						addr_ff <= addr_ff + AW'(1);
						left_ff <= left_ff - BW'(1);
						if (left_ff == BW'(1)) state_ff <= ST_IDLE;
					end
				end
				ST_WR: begin
					if (wr_take) begin
						addr_ff <= addr_ff + AW'(1);
						left_ff <= left_ff - BW'(1);
						// respond only once the final beat is in
						if (left_ff == BW'(1)) state_ff <= ST_WRSP;
					end
				end
				ST_WRSP: begin
					// the pulse is raised on the way out, so idle follows
					if (!wvalid_ff) state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// one pair of error flags per command collects bad beats of a burst;
	// a beat past the array is a decode fault, a rom write without debug
	// access a slave fault, and the decode fault wins if both are seen
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			wr_bad_ff <= 1'b0;
			wr_dec_ff <= 1'b0;
		end else if (wr_take) begin
			wr_bad_ff <= (state_ff == ST_WR ? wr_bad_ff : 1'b0) ||
				(cfg_rom && !bus.debugaccess);
			wr_dec_ff <= (state_ff == ST_WR ? wr_dec_ff : 1'b0) ||
				!wr_in_range;
		end
	end

	// one byte array per lane, so that no word of storage is written
	// from two processes; rom blocks all but debug writes
	genvar g;
	generate
		for (g = 0; g < NB; g++) begin : g_lane
			logic [7:0] lane_mem_ff [WORDS];
			always_ff @(posedge bus.sys_clk) begin
				if (wr_take && wr_in_range && lane_en[g] &&
					(!cfg_rom || bus.debugaccess)) begin
					lane_mem_ff[wr_idx] <= bus.writedata[g*8 +: 8];
				end
			end
			// reads gather every lane whatever the enables say
			assign rd_word[g*8 +: 8] = lane_mem_ff[rd_idx];
		end
	endgenerate

	// read beats: full word regardless of byte enables, reads are pure
	// an out-of-range beat carries zeros, never stale array contents
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			rdata_ff <= '0;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= rd_beat;
			if (rd_beat) begin
				rdata_ff <= in_range ? rd_word : '0;
			end
		end
	end

	// write response pulse, exactly one per command
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			wvalid_ff <= 1'b0;
		end else begin
			wvalid_ff <= (state_ff == ST_WRSP) && !wvalid_ff;
		end
	end

	// response code; held at okay outside valid cycles
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			rsp_ff <= MMR_OKAY;
		end else if (rd_beat) begin
			rsp_ff <= in_range ? MMR_OKAY : MMR_DECERR;
		end else if (state_ff == ST_WRSP && !wvalid_ff) begin
			if (wr_dec_ff) rsp_ff <= MMR_DECERR;
			else if (wr_bad_ff) rsp_ff <= MMR_SLVERR;
			else rsp_ff <= MMR_OKAY;
		end else begin
			rsp_ff <= MMR_OKAY;
		end
	end

	// sticky error seen, for observation
	// held until reset so that a single bad beat is never missed
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			err_ff <= 1'b0;
		end else if ((rvalid_ff || wvalid_ff) && rsp_ff != MMR_OKAY) begin
			err_ff <= 1'b1;
		end
	end

	// every answer comes straight from a flip-flop
	assign bus.readdata = rdata_ff;
	assign bus.readdatavalid = rvalid_ff;
	assign bus.writeresponsevalid = wvalid_ff;
	assign bus.response = rsp_ff;
	assign stat_err_seen = err_ff;
endmodule

// ===== rtl/mmr_params.svh
// timing and encoding constants for the memory-mapped slave response block
`ifndef MMR_PARAMS_SVH
`define MMR_PARAMS_SVH
`define MMR_RSP_OKAY 2'h0
`define MMR_RSP_RSVD 2'h1
`define MMR_RSP_SLVERR 2'h2
`define MMR_RSP_DECERR 2'h3
`define MMR_DATA_W 32
`define MMR_ADDR_W 8
`define MMR_BURST_W 8
`define MMR_MEM_WORDS 64
`define MMR_RD_LAT 1
`endif

// ===== rtl/mmr_pkg.sv
// types shared by both ends of the memory-mapped slave response block
`include "mmr_params.svh"
package mmr_pkg;
	typedef enum logic [1:0] {
		MMR_OKAY = `MMR_RSP_OKAY,
		MMR_RSVD = `MMR_RSP_RSVD,
		MMR_SLVERR = `MMR_RSP_SLVERR,
		MMR_DECERR = `MMR_RSP_DECERR
	} mmr_rsp_t;
endpackage

// ===== rtl/mmr_if.sv
// bus signals between the master end and the slave end
`include "mmr_params.svh"
interface mmr_if #(
	parameter int DW = `MMR_DATA_W,
	parameter int AW = `MMR_ADDR_W,
	parameter int BW = `MMR_BURST_W
) (
	input wire logic sys_clk,
	input wire logic rstn
);
	logic [AW-1:0] address;
	logic [DW/8-1:0] byteenable;
	logic read;
	logic write;
	logic [DW-1:0] writedata;
	logic [BW-1:0] burstcount;
	logic debugaccess;
	logic waitrequest;
	logic [DW-1:0] readdata;
	logic readdatavalid;
	logic [1:0] response;
	logic writeresponsevalid;
	modport mst (
		input sys_clk, rstn, waitrequest, readdata, readdatavalid,
		input response, writeresponsevalid,
		output address, byteenable, read, write, writedata, burstcount,
		output debugaccess
	);
	modport slv (
		input sys_clk, rstn, address, byteenable, read, write, writedata,
		input burstcount, debugaccess,
		output waitrequest, readdata, readdatavalid, response,
		output writeresponsevalid
	);
endinterface

// ===== rtl/mmr_master.sv
// master end: issues read and write bursts, collects per-beat responses
`include "mmr_params.svh"
module mmr_master #(
	parameter int DW = `MMR_DATA_W,
	parameter int AW = `MMR_ADDR_W,
	parameter int BW = `MMR_BURST_W
) (
	// bus side
	mmr_if.mst bus,
	// user command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic cmd_debug,
	input wire logic [AW-1:0] cmd_addr,
	input wire logic [BW-1:0] cmd_len,
	input wire logic [DW/8-1:0] cmd_be,
	input wire logic [DW-1:0] cmd_wdata,
	// user answer
	output logic rsp_valid,
	output logic rsp_is_write,
	output logic [DW-1:0] rsp_data,
	output mmr_pkg::mmr_rsp_t rsp_code
);
	import mmr_pkg::*;
	localparam int NB = DW / 8;
	typedef enum {ST_IDLE, ST_RCMD, ST_RWAIT, ST_WBEAT, ST_WWAIT} mmr_mst_t;

	mmr_mst_t state_ff;
	logic [AW-1:0] addr_ff;
	logic [BW-1:0] len_ff;
	logic [BW-1:0] left_ff;
	logic [NB-1:0] be_ff;
	logic [DW-1:0] wdata_ff;
	logic dbg_ff;
	logic rv_ff;
	logic rw_ff;
	logic [DW-1:0] rd_ff;
	mmr_rsp_t rc_ff;
	logic [NB-1:0] be_fix;

	// keep only the lowest contiguous run of lanes; gaps are illegal
	always_comb begin
		be_fix = cmd_be;
		if (cmd_be == '0) be_fix = {NB{1'b1}};
		else if ((((cmd_be | (cmd_be - NB'(1))) + NB'(1)) & cmd_be) != '0)
			be_fix = cmd_be & ~(cmd_be + (cmd_be & ~(cmd_be - NB'(1))));
	end

	assign cmd_ready = (state_ff == ST_IDLE);

	// command sequencing
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			state_ff <= ST_IDLE;
			addr_ff <= '0;
			len_ff <= '0;
			left_ff <= '0;
			be_ff <= '0;
			wdata_ff <= '0;
			dbg_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (cmd_valid) begin
						addr_ff <= cmd_addr;
						len_ff <= (cmd_len == '0) ? BW'(1) : cmd_len;
						left_ff <= (cmd_len == '0) ? BW'(1) : cmd_len;
						be_ff <= be_fix;
						wdata_ff <= cmd_wdata;
						dbg_ff <= cmd_debug;
						state_ff <= cmd_write ? ST_WBEAT : ST_RCMD;
					end
				end
				ST_RCMD: begin
					if (!bus.waitrequest) state_ff <= ST_RWAIT;
				end
				ST_RWAIT: begin
					if (bus.readdatavalid) begin
						left_ff <= left_ff - BW'(1);
						if (left_ff == BW'(1)) state_ff <= ST_IDLE;
					end
				end
				ST_WBEAT: begin
					if (!bus.waitrequest) begin
						left_ff <= left_ff - BW'(1);
						wdata_ff <= wdata_ff + DW'(1);
						if (left_ff == BW'(1)) state_ff <= ST_WWAIT;
					end
				end
				ST_WWAIT: begin
					if (bus.writeresponsevalid) state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// answers to the user; error beats carry zero data
	always_ff @(posedge bus.sys_clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			rv_ff <= 1'b0;
			rw_ff <= 1'b0;
			rd_ff <= '0;
			rc_ff <= MMR_OKAY;
		end else begin
			rv_ff <= (state_ff == ST_RWAIT && bus.readdatavalid) ||
				(state_ff == ST_WWAIT && bus.writeresponsevalid);
			rw_ff <= bus.writeresponsevalid;
			if (bus.readdatavalid || bus.writeresponsevalid) begin
				rc_ff <= mmr_rsp_t'(bus.response);
				rd_ff <= (bus.readdatavalid && bus.response == MMR_OKAY) ?
					bus.readdata : '0;
			end
		end
	end

	assign bus.address = addr_ff;
	assign bus.byteenable = be_ff;
	assign bus.read = (state_ff == ST_RCMD);
	assign bus.write = (state_ff == ST_WBEAT);
	assign bus.writedata = wdata_ff;
	assign bus.burstcount = len_ff;
	assign bus.debugaccess = dbg_ff;
	assign rsp_valid = rv_ff;
	assign rsp_is_write = rw_ff;
	assign rsp_data = rd_ff;
	assign rsp_code = rc_ff;
endmodule

// ===== verif/mmr_bus_chk.sv
// concurrent checks on the bus that joins the master end and the slave end
module mmr_bus_chk #(
	parameter int BW = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// master to slave
	input wire logic [3:0] byteenable,
	input wire logic read,
	input wire logic write,
	input wire logic [BW-1:0] burstcount,
	// slave to master
	input wire logic waitrequest,
	input wire logic readdatavalid,
	input wire logic [1:0] response,
	input wire logic writeresponsevalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [BW-1:0] blen;
	logic [BW-1:0] wcnt_ff;
	logic [BW-1:0] rleft_ff;
	logic wr_take;
	logic wr_last;
	// a zero burst count stands for one beat
	assign blen = (burstcount == '0) ? BW'(1) : burstcount;
	assign wr_take = write && !waitrequest;
	assign wr_last = wr_take && (wcnt_ff + BW'(1) == blen);
	// write beats taken so far in the current burst
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) wcnt_ff <= '0;
		else if (wr_last) wcnt_ff <= '0;
		else if (wr_take) wcnt_ff <= wcnt_ff + BW'(1);
	end
	// read beats still owed; catches short and long bursts alike
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) rleft_ff <= '0;
		else if (read && !waitrequest) rleft_ff <= blen;
		else if (readdatavalid) rleft_ff <= rleft_ff - BW'(1);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_rd_take;
		read && !waitrequest;
	endsequence
	sequence s_beat;
		readdatavalid ##1 !readdatavalid;
	endsequence
	a_rd_first_beat: assert property (s_rd_take |-> ##2 s_beat)
		else $error("first read beat late or missing");
	a_rd_next_beat: assert property (
		readdatavalid && rleft_ff > BW'(1) |-> ##2 s_beat)
		else $error("next read beat not two cycles on");
	a_rd_no_extra: assert property (readdatavalid |-> rleft_ff != '0)
		else $error("read beat beyond burst length");
	a_rd_all_beats: assert property ($fell(waitrequest) |-> rleft_ff == '0)
		else $error("burst ended with beats owed");
	a_wr_resp_lat: assert property (wr_last |-> ##2 writeresponsevalid)
		else $error("write response missing");
	a_wr_resp_cause: assert property (
		writeresponsevalid |-> $past(wr_last, 2))
		else $error("write response without last beat");
	a_no_both_valid: assert property (
		!(readdatavalid && writeresponsevalid))
		else $error("read and write response together");
	a_no_rsvd_code: assert property (response != 2'h1)
		else $error("reserved response code");
	a_rsp_when_valid: assert property (
		!(readdatavalid || writeresponsevalid) |-> response == 2'h0)
		else $error("response outside valid cycle");
	a_be_lanes_adjacent: assert property (
		read || write |-> byteenable inside {4'h1, 4'h2, 4'h4, 4'h8,
		4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf})
		else $error("byte lanes not adjacent");
endmodule

// ===== verif/testbench.sv
// self-checking bench joining the master end to the slave end
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mmr_pkg::*;
	logic sys_clk, rstn, cmd_valid, cmd_write, cmd_debug, cfg_rom;
	logic [7:0] cmd_addr, cmd_len;
	logic [3:0] cmd_be;
	logic [31:0] cmd_wdata, rsp_data;
	logic cmd_ready, rsp_valid, rsp_is_write, stat_err_seen;
	mmr_rsp_t rsp_code;
	int n_mismatch, checks;
	logic [31:0] dq [8];
	mmr_rsp_t cq [8];
	logic wq;
	mmr_if mmr_if_i (.sys_clk(sys_clk), .rstn(rstn));
	mmr_master mmr_master_i (.bus(mmr_if_i), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_debug(cmd_debug),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_be(cmd_be),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_is_write(rsp_is_write), .rsp_data(rsp_data),
		.rsp_code(rsp_code));
	mmr_slave mmr_slave_i (.bus(mmr_if_i), .cfg_rom(cfg_rom),
		.stat_err_seen(stat_err_seen));
	mmr_bus_chk mmr_bus_chk_i (.sys_clk(mmr_if_i.sys_clk),
		.rstn(mmr_if_i.rstn), .byteenable(mmr_if_i.byteenable),
		.read(mmr_if_i.read), .write(mmr_if_i.write),
		.burstcount(mmr_if_i.burstcount),
		.waitrequest(mmr_if_i.waitrequest),
		.readdatavalid(mmr_if_i.readdatavalid),
		.response(mmr_if_i.response),
		.writeresponsevalid(mmr_if_i.writeresponsevalid));
	// one command, then every beat or write answer it owes
	task automatic op(input logic w, d, input logic [7:0] a, l,
		input logic [3:0] be, input logic [31:0] wd);
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
		{cmd_write, cmd_debug, cmd_addr, cmd_len} = {w, d, a, l};
		cmd_be = be;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (int i = 0; i < (w ? 1 : int'(l)); i++) begin
			k = 0;
			do begin
				@(negedge sys_clk);
				k++;
			end while (rsp_valid !== 1'b1 && k < 50);
			`CHK(rsp_valid, 1'b1)
			dq[i] = rsp_data;
			cq[i] = rsp_code;
			wq = rsp_is_write;
		end
		`CHK(cmd_ready, 1'b1)
	endtask
	// full word written, read back with a single lane enabled
	task t_word;
		op(1'b1, 1'b0, 8'h00, 8'h01, 4'hf, 32'h1234_5678);
		`CHK(cq[0], MMR_OKAY)
		`CHK(wq, 1'b1)
		op(1'b0, 1'b0, 8'h00, 8'h01, 4'h1, 32'h0000_0000);
		`CHK(dq[0], 32'h1234_5678)
		`CHK(wq, 1'b0)
	endtask
	// lane writes; the gapped mask is cut to its lowest run by the master
	task t_lanes;
		op(1'b1, 1'b0, 8'h00, 8'h01, 4'h2, 32'haabb_ccdd);
		op(1'b1, 1'b0, 8'h00, 8'h01, 4'h5, 32'h1122_3344);
		op(1'b0, 1'b0, 8'h00, 8'h01, 4'hf, 32'h0000_0000);
		`CHK(dq[0], 32'h1234_cc44)
	endtask
	// four-beat write burst, then the same four read back
	task t_burst;
		op(1'b1, 1'b0, 8'h04, 8'h04, 4'hf, 32'h0000_0a00);
		`CHK(cq[0], MMR_OKAY)
		op(1'b0, 1'b0, 8'h04, 8'h04, 4'hf, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			`CHK(dq[i], 32'h0000_0a00 + i)
		end
	endtask
	// burst running off the end of memory: statuses differ per beat
	task t_edge;
		`CHK(stat_err_seen, 1'b0)
		op(1'b0, 1'b0, 8'h3e, 8'h03, 4'hf, 32'h0000_0000);
		`CHK(cq[0], MMR_OKAY)
		`CHK(cq[1], MMR_OKAY)
		`CHK(cq[2], MMR_DECERR)
		`CHK(dq[2], 32'h0000_0000)
		`CHK(stat_err_seen, 1'b1)
		op(1'b1, 1'b0, 8'h40, 8'h01, 4'hf, 32'h0000_0001);
		`CHK(cq[0], MMR_DECERR)
	endtask
	// read-only memory takes writes only under debug access
	task t_rom;
		op(1'b1, 1'b0, 8'h01, 8'h01, 4'hf, 32'h5555_0001);
		cfg_rom = 1'b1;
		op(1'b1, 1'b0, 8'h01, 8'h01, 4'hf, 32'hdead_0001);
		`CHK(cq[0], MMR_SLVERR)
		op(1'b1, 1'b1, 8'h02, 8'h01, 4'hf, 32'hbeef_0002);
		`CHK(cq[0], MMR_OKAY)
		op(1'b0, 1'b0, 8'h01, 8'h02, 4'hf, 32'h0000_0000);
		`CHK(dq[0], 32'h5555_0001)
		`CHK(dq[1], 32'hbeef_0002)
		cfg_rom = 1'b0;
	endtask
	task close_out;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// the whole sequence needs about a hundred cycles; allow 5000
	initial begin
		#500000;
		n_mismatch++;
		close_out();
	end
	initial begin
		{rstn, cmd_valid, cmd_write, cmd_debug, cfg_rom} = 5'h00;
		{cmd_addr, cmd_len, cmd_be, cmd_wdata} = '0;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		t_word();
		t_lanes();
		t_burst();
		t_edge();
		t_rom();
		close_out();
	end
endmodule
